// *** logic/bfs_pkg.sv ***
/*
 * Package for the block floating-point scaling control: instruction
 * codes, field widths, reset values and the carrier structs.
 * Assumes a single synchronous clock domain shared by all users.
 */
package bfs_pkg;

    localparam int ACC_W       = 40;
    localparam int MSB_POS     = 31;
    localparam int EXT_LO      = 32;
    localparam int FIELD_W     = 4;
    localparam int STATUS_W    = 8;
    localparam int SC_LSB      = 0;
    localparam int PM_LSB      = 4;
    localparam logic [3:0] PM_RESET   = 4'h8;
    localparam logic [3:0] SC_RESET   = 4'h0;
    localparam logic [3:0] BG_RESET   = 4'h0;
    localparam logic [3:0] MAG_MAX    = 4'h7;
    localparam logic [3:0] MAG_MIN    = 4'h9;
    localparam logic [2:0] SHIFT_MAX  = 3'h7;

    typedef enum logic [3:0] {
        BFS_NOP,
        BFS_RESET_PM,
        BFS_WRITE_SC,
        BFS_WRITE_PM,
        BFS_WRITE_BG,
        BFS_WRITE_STATUS,
        BFS_UPDATE_SC,
        BFS_EQUALIZE,
        BFS_OUTPUT
    } bfs_op_t;

    typedef struct packed {
        bfs_op_t     op;
        logic        sel_b;
        logic        twos;
        logic [7:0]  data;
    } bfs_instr_t;

    typedef struct packed {
        logic [3:0] shift_control;
        logic [3:0] pass_magnitude;
        logic [3:0] bit_growth;
    } bfs_set_t;

    typedef struct packed {
        bfs_set_t   set_a;
        bfs_set_t   set_b;
        logic [7:0] status_a;
        logic [7:0] status_b;
    } bfs_state_t;

endpackage

// *** logic/bfs_magnitude.sv ***
/*
 * Magnitude evaluator: finds the signed exponent of a 40-bit accumulator
 * value relative to full normalization, clamped to -7..+7.
 * Assumes the value is sampled before any output shift is applied.
 */
`timescale 1ns/10ps
module bfs_magnitude #(
    parameter int ACC_WIDTH = 40
) (
    // Accumulator value
    input  wire logic [ACC_WIDTH-1:0] value,
    input  wire logic                 twos,
    // Result
    output logic      [3:0]           magnitude
);
    logic [ACC_WIDTH-1:0] probe;
    logic [5:0]           lead;
    logic                 found;
    int                   k;

    always_comb begin
        // Compare against sign for 2sC, against zero for unsigned
        probe = twos ? (value ^ {ACC_WIDTH{value[ACC_WIDTH-1]}}) : value;
        lead  = 6'h00;
        found = 1'b0;
        for (k = ACC_WIDTH - 1; k >= 0; k--) begin
            if (!found && probe[k]) begin
                lead  = 6'(k);
                found = 1'b1;
            end
        end
        // 2sC: first differing bit normalizes at 30; unsigned at 31
        if (twos) begin
            lead = lead + 6'h01;
        end
        if (!found) begin
            magnitude = bfs_pkg::MAG_MIN;
        end else if (lead > 6'd38) begin
            magnitude = bfs_pkg::MAG_MAX;
        end else if (lead < 6'd24) begin
            magnitude = bfs_pkg::MAG_MIN;
        end else begin
            // Zero when lead is 31
            magnitude = 4'(lead - 6'd31);
        end
    end

endmodule

// *** logic/bfs_ctrl.sv ***
/*
 * Block floating-point scaling control for a two-accumulator integer
 * arithmetic unit. Holds shift control, pass magnitude and bit growth per
 * accumulator, tracks output magnitude and computes the next shift.
 * Assumes instructions and input port data are synchronous to clock and
 * that the sequencer issues at most one instruction per cycle.
 */
`timescale 1ns/10ps
// Overview of operation
// - Pass magnitude is 4-bit signed, -7..+7
// - Pattern 1000 from reset, reset instruction or port write, never from tracking
// - Two independent register sets, A and B
// - Shift control written from port or updated
// - Pass magnitude reset, loaded, else tracked
// - Bit growth loaded from port bits 3-0
// - Bit growth held until rewritten
// - Track only output values, before shifting
// - Twos-complement normalized value has magnitude zero
// - Unsigned normalized value has magnitude zero
// - One magnitude step per bit position
// - Replace pass magnitude when new greater
// - Update: growth plus magnitude minus shift
// - Equalize loads larger of two shifts
// - Output shifted by shift control amount
// - Shift and magnitude readable in status
// - Negative shifts left, -8 shifts seven
module bfs_ctrl #(
    parameter int ACC_WIDTH = bfs_pkg::ACC_W
) (
    // Clock and reset
    input  wire logic                 clock,
    input  wire logic                 rst_b,
    // Instruction from sequencer
    input  wire bfs_pkg::bfs_instr_t  instr,
    // Accumulator values presented for output
    input  wire logic [ACC_WIDTH-1:0] acc_a,
    input  wire logic [ACC_WIDTH-1:0] acc_b,
    // Shift amounts toward the output shifter
    output logic                      shift_left_a,
    output logic      [2:0]           shift_amount_a,
    output logic                      shift_left_b,
    output logic      [2:0]           shift_amount_b,
    // Status fields
    output logic      [7:0]           status_a,
    output logic      [7:0]           status_b
);
    bfs_pkg::bfs_state_t  state;
    bfs_pkg::bfs_state_t  next_state;
    logic [ACC_WIDTH-1:0] out_value;
    logic [3:0]           out_magnitude;
    logic                 out_twos;
    bfs_pkg::bfs_set_t    cur;
    bfs_pkg::bfs_set_t    upd;
    logic signed [3:0]    sc_a_s;
    logic signed [3:0]    sc_b_s;
    logic signed [3:0]    sc_max;

    // Only the value actually leaving is evaluated, unshifted
    assign out_value = instr.sel_b ? acc_b : acc_a;
    assign out_twos  = instr.twos;

    bfs_magnitude #(
        .ACC_WIDTH (ACC_WIDTH)
    ) u_magnitude (
        .value     (out_value),
        .twos      (out_twos),
        .magnitude (out_magnitude)
    );

    assign sc_a_s = $signed(state.set_a.shift_control);
    assign sc_b_s = $signed(state.set_b.shift_control);
    assign sc_max = (sc_a_s > sc_b_s) ? sc_a_s : sc_b_s;

    always_comb begin
        next_state = state;
        cur = instr.sel_b ? state.set_b : state.set_a;
        upd = cur;
        unique case (instr.op)
            bfs_pkg::BFS_RESET_PM: begin
                upd.pass_magnitude = bfs_pkg::PM_RESET;
            end
            bfs_pkg::BFS_WRITE_SC: begin
                upd.shift_control = instr.data[3:0];
            end
            bfs_pkg::BFS_WRITE_PM: begin
                upd.pass_magnitude = instr.data[3:0];
            end
            bfs_pkg::BFS_WRITE_BG: begin
                upd.bit_growth = instr.data[3:0];
            end
            bfs_pkg::BFS_WRITE_STATUS: begin
                upd.shift_control  = instr.data[bfs_pkg::SC_LSB +: bfs_pkg::FIELD_W];
                upd.pass_magnitude = instr.data[bfs_pkg::PM_LSB +: bfs_pkg::FIELD_W];
            end
            bfs_pkg::BFS_UPDATE_SC: begin
                // Signed wrap to four bits
                upd.shift_control = 4'($signed(cur.bit_growth)
                    + $signed(cur.pass_magnitude)
                    - $signed(cur.shift_control));
            end
            bfs_pkg::BFS_EQUALIZE: begin
                upd.shift_control = sc_max;
            end
            bfs_pkg::BFS_OUTPUT: begin
                if ($signed(out_magnitude) > $signed(cur.pass_magnitude)) begin
                    upd.pass_magnitude = out_magnitude;
                end
            end
            default: begin
                upd = cur;
            end
        endcase
        if (instr.sel_b) begin
            next_state.set_b = upd;
        end else begin
            next_state.set_a = upd;
        end
        next_state.status_a = {next_state.set_a.pass_magnitude,
                               next_state.set_a.shift_control};
        next_state.status_b = {next_state.set_b.pass_magnitude,
                               next_state.set_b.shift_control};
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            state <= '{set_a:    '{bfs_pkg::SC_RESET, bfs_pkg::PM_RESET, bfs_pkg::BG_RESET},
                       set_b:    '{bfs_pkg::SC_RESET, bfs_pkg::PM_RESET, bfs_pkg::BG_RESET},
                       status_a: {bfs_pkg::PM_RESET, bfs_pkg::SC_RESET},
                       status_b: {bfs_pkg::PM_RESET, bfs_pkg::SC_RESET}};
        end else begin
            state <= next_state;
        end
    end

    // -8 still shifts left by seven only
    assign shift_left_a   = state.set_a.shift_control[3];
    assign shift_amount_a = (state.set_a.shift_control == bfs_pkg::PM_RESET) ? bfs_pkg::SHIFT_MAX
                          : 3'(shift_left_a ? -sc_a_s : sc_a_s);
    assign shift_left_b   = state.set_b.shift_control[3];
    assign shift_amount_b = (state.set_b.shift_control == bfs_pkg::PM_RESET) ? bfs_pkg::SHIFT_MAX
                          : 3'(shift_left_b ? -sc_b_s : sc_b_s);
    assign status_a = state.status_a;
    assign status_b = state.status_b;

    // Instruction steps seen at the port, shared by the checks below
    sequence out_a_seq;
        instr.op == bfs_pkg::BFS_OUTPUT && !instr.sel_b;
    endsequence

    sequence out_b_seq;
        instr.op == bfs_pkg::BFS_OUTPUT && instr.sel_b;
    endsequence

    sequence clear_a_seq;
        instr.op == bfs_pkg::BFS_RESET_PM && !instr.sel_b;
    endsequence

    sequence clear_b_seq;
        instr.op == bfs_pkg::BFS_RESET_PM && instr.sel_b;
    endsequence

    // Pass start: clear A, one idle cycle, clear B
    sequence pass_start_seq;
        clear_a_seq ##1 instr.op == bfs_pkg::BFS_NOP ##1 clear_b_seq;
    endsequence

    // Tracking never yields the reset pattern
    track_range_a : assert property (@(posedge clock) disable iff (!rst_b)
        out_a_seq |=> state.set_a.pass_magnitude != bfs_pkg::PM_RESET)
        else $error("tracking produced reset pattern");

    track_b_a : assert property (@(posedge clock) disable iff (!rst_b)
        out_b_seq |=> state.set_b.pass_magnitude != bfs_pkg::PM_RESET)
        else $error("tracking B produced reset pattern");

    pass_start_a : assert property (@(posedge clock) disable iff (!rst_b)
        pass_start_seq |=> state.set_a.pass_magnitude == bfs_pkg::PM_RESET
        && state.set_b.pass_magnitude == bfs_pkg::PM_RESET)
        else $error("pass start left a magnitude set");

    pm_clear_a : assert property (@(posedge clock) disable iff (!rst_b)
        clear_a_seq |=> state.set_a.pass_magnitude == bfs_pkg::PM_RESET)
        else $error("pass magnitude A not reset");

    growth_hold_a : assert property (@(posedge clock) disable iff (!rst_b)
        !(instr.op == bfs_pkg::BFS_WRITE_BG && !instr.sel_b) |=> $stable(state.set_a.bit_growth))
        else $error("bit growth A changed without write");

    sets_indep_a : assert property (@(posedge clock) disable iff (!rst_b)
        instr.sel_b |=> $stable(state.set_a))
        else $error("set A changed on set B instruction");

    pm_max_a : assert property (@(posedge clock) disable iff (!rst_b)
        instr.op == bfs_pkg::BFS_OUTPUT && !instr.sel_b
        && $signed(out_magnitude) > $signed(state.set_a.pass_magnitude)
        |=> state.set_a.pass_magnitude == $past(out_magnitude))
        else $error("pass magnitude A not raised");

    pm_reset_a : assert property (@(posedge clock) disable iff (!rst_b)
        instr.op == bfs_pkg::BFS_RESET_PM && instr.sel_b
        |=> state.set_b.pass_magnitude == bfs_pkg::PM_RESET)
        else $error("pass magnitude B not reset");

    sc_update_a : assert property (@(posedge clock) disable iff (!rst_b)
        instr.op == bfs_pkg::BFS_UPDATE_SC && !instr.sel_b
        |=> state.set_a.shift_control == 4'($past(state.set_a.bit_growth)
            + $past(state.set_a.pass_magnitude) - $past(state.set_a.shift_control)))
        else $error("shift control A update wrong");

    equalize_b_a : assert property (@(posedge clock) disable iff (!rst_b)
        instr.op == bfs_pkg::BFS_EQUALIZE && instr.sel_b
        |=> state.set_b.shift_control == ($signed($past(state.set_a.shift_control))
            > $signed($past(state.set_b.shift_control)) ? $past(state.set_a.shift_control)
            : $past(state.set_b.shift_control)))
        else $error("equalize B wrong");

    status_sync_a : assert property (@(posedge clock) disable iff (!rst_b)
        status_b == {state.set_b.pass_magnitude, state.set_b.shift_control})
        else $error("status B mismatch");

    shift_clamp_a : assert property (@(posedge clock) disable iff (!rst_b)
        state.set_a.shift_control == bfs_pkg::PM_RESET |-> shift_left_a && shift_amount_a == 3'h7)
        else $error("shift -8 not clamped to seven");

    norm_zero_a : assert property (@(posedge clock) disable iff (!rst_b)
        instr.twos && out_value[ACC_WIDTH-1:30] == {{(ACC_WIDTH-31){out_value[31]}}, ~out_value[31]}
        |-> out_magnitude == 4'h0)
        else $error("normalized 2sC value not zero");

    norm_unsigned_a : assert property (@(posedge clock) disable iff (!rst_b)
        !instr.twos && out_value[ACC_WIDTH-1:31] == {{(ACC_WIDTH-32){1'b0}}, 1'b1}
        |-> out_magnitude == 4'h0)
        else $error("normalized unsigned value not zero");

    mag_range_a : assert property (@(posedge clock) disable iff (!rst_b)
        out_magnitude != bfs_pkg::PM_RESET)
        else $error("magnitude outside seven steps");

    idle_hold_a : assert property (@(posedge clock) disable iff (!rst_b)
        instr.op == bfs_pkg::BFS_NOP |=> $stable(state))
        else $error("state changed without instruction");

    growth_b_a : assert property (@(posedge clock) disable iff (!rst_b)
        !(instr.op == bfs_pkg::BFS_WRITE_BG && instr.sel_b)
        |=> $stable(state.set_b.bit_growth))
        else $error("bit growth B changed without write");

    indep_b_a : assert property (@(posedge clock) disable iff (!rst_b)
        !instr.sel_b |=> $stable(state.set_b))
        else $error("set B changed on set A instruction");

    pm_max_b_a : assert property (@(posedge clock) disable iff (!rst_b)
        instr.op == bfs_pkg::BFS_OUTPUT && instr.sel_b
        && $signed(out_magnitude) > $signed(state.set_b.pass_magnitude)
        |=> state.set_b.pass_magnitude == $past(out_magnitude))
        else $error("pass magnitude B not raised");

    pm_keep_a : assert property (@(posedge clock) disable iff (!rst_b)
        instr.op == bfs_pkg::BFS_OUTPUT && !instr.sel_b
        && $signed(out_magnitude) <= $signed(state.set_a.pass_magnitude)
        |=> $stable(state.set_a.pass_magnitude))
        else $error("pass magnitude A lowered");

    // Port writes land unchanged in the selected set
    bg_load_a : assert property (@(posedge clock) disable iff (!rst_b)
        instr.op == bfs_pkg::BFS_WRITE_BG && !instr.sel_b
        |=> state.set_a.bit_growth == $past(instr.data[3:0]))
        else $error("bit growth A not loaded");

    sc_write_a : assert property (@(posedge clock) disable iff (!rst_b)
        instr.op == bfs_pkg::BFS_WRITE_SC && !instr.sel_b
        |=> state.set_a.shift_control == $past(instr.data[3:0]))
        else $error("shift control A not loaded");

    sc_write_b_a : assert property (@(posedge clock) disable iff (!rst_b)
        instr.op == bfs_pkg::BFS_WRITE_SC && instr.sel_b
        |=> state.set_b.shift_control == $past(instr.data[3:0]))
        else $error("shift control B not loaded");

    pm_write_a : assert property (@(posedge clock) disable iff (!rst_b)
        instr.op == bfs_pkg::BFS_WRITE_PM && !instr.sel_b
        |=> state.set_a.pass_magnitude == $past(instr.data[3:0]))
        else $error("pass magnitude A not loaded");

    status_b_a : assert property (@(posedge clock) disable iff (!rst_b)
        instr.op == bfs_pkg::BFS_WRITE_STATUS && instr.sel_b
        |=> status_b == $past(instr.data))
        else $error("status B not loaded");

    sc_hold_a : assert property (@(posedge clock) disable iff (!rst_b)
        instr.sel_b || !(instr.op inside {bfs_pkg::BFS_WRITE_SC, bfs_pkg::BFS_WRITE_STATUS,
                                          bfs_pkg::BFS_UPDATE_SC, bfs_pkg::BFS_EQUALIZE})
        |=> $stable(state.set_a.shift_control))
        else $error("shift control A changed without instruction");

    update_b_a : assert property (@(posedge clock) disable iff (!rst_b)
        instr.op == bfs_pkg::BFS_UPDATE_SC && instr.sel_b
        |=> state.set_b.shift_control == 4'($past(state.set_b.bit_growth)
            + $past(state.set_b.pass_magnitude) - $past(state.set_b.shift_control)))
        else $error("shift control B update wrong");

    equalize_a_a : assert property (@(posedge clock) disable iff (!rst_b)
        instr.op == bfs_pkg::BFS_EQUALIZE && !instr.sel_b
        |=> state.set_a.shift_control == ($signed($past(state.set_a.shift_control))
            > $signed($past(state.set_b.shift_control)) ? $past(state.set_a.shift_control)
            : $past(state.set_b.shift_control)))
        else $error("equalize A wrong");

    status_match_a : assert property (@(posedge clock) disable iff (!rst_b)
        status_a == {state.set_a.pass_magnitude, state.set_a.shift_control})
        else $error("status A mismatch");

    // Output shifter decode, both directions
    clamp_b_a : assert property (@(posedge clock) disable iff (!rst_b)
        state.set_b.shift_control == bfs_pkg::PM_RESET |-> shift_left_b && shift_amount_b == 3'h7)
        else $error("shift B -8 not clamped to seven");

    shift_right_a : assert property (@(posedge clock) disable iff (!rst_b)
        !state.set_a.shift_control[3]
        |-> !shift_left_a && shift_amount_a == state.set_a.shift_control[2:0])
        else $error("positive shift A decoded wrong");

    right_b_a : assert property (@(posedge clock) disable iff (!rst_b)
        !state.set_b.shift_control[3]
        |-> !shift_left_b && shift_amount_b == state.set_b.shift_control[2:0])
        else $error("positive shift B decoded wrong");

    shift_neg_a : assert property (@(posedge clock) disable iff (!rst_b)
        state.set_a.shift_control[3] && state.set_a.shift_control != bfs_pkg::PM_RESET
        |-> shift_left_a && shift_amount_a == 3'(4'h0 - state.set_a.shift_control))
        else $error("negative shift A decoded wrong");

    left_b_a : assert property (@(posedge clock) disable iff (!rst_b)
        state.set_b.shift_control[3] && state.set_b.shift_control != bfs_pkg::PM_RESET
        |-> shift_left_b && shift_amount_b == 3'(4'h0 - state.set_b.shift_control))
        else $error("negative shift B decoded wrong");

endmodule

// *** sim/bfs_seq_model.sv ***
/*
 * Sequencer model: issues one instruction at a time to the scaling
 * control, with a gap cycle after each.
 * Assumes the bench owns the clock and releases reset before any call.
 */
`timescale 1ns/10ps
module bfs_seq_model (
    // Clock
    input  wire logic          clock,
    // Instruction toward the block
    output bfs_pkg::bfs_instr_t instr
);
    initial instr = '0;

    // Gap cycle so an output or update never repeats by being held
    task automatic issue(input bfs_pkg::bfs_op_t op, input logic sel_b,
                         input logic twos, input logic [7:0] data);
        @(posedge clock);
        #1 instr = '{op, sel_b, twos, data};
        @(posedge clock);
        #1 instr.op = bfs_pkg::BFS_NOP;
    endtask

    task automatic start_pass();
        issue(bfs_pkg::BFS_RESET_PM, 1'b0, 1'b0, 8'h00);
        issue(bfs_pkg::BFS_RESET_PM, 1'b1, 1'b0, 8'h00);
    endtask

    // Normalized input assumed, so shift starts equal to growth
    task automatic preload(input logic sel_b, input logic [3:0] growth);
        issue(bfs_pkg::BFS_WRITE_BG, sel_b, 1'b0, {4'h0, growth});
        issue(bfs_pkg::BFS_WRITE_SC, sel_b, 1'b0, {4'h0, growth});
    endtask
endmodule

// *** sim/block_float_scaling_ctrl_test.sv ***
/*
 * Self-checking bench for the scaling control: instruction sequences
 * through the sequencer model, status and shifter outputs compared.
 * Assumes one 100 MHz clock and inputs driven 1 ns after each edge.
 */
`timescale 1ns/10ps
module block_float_scaling_ctrl_test;
    logic                clock = 1'b0;
    logic                rst_b = 1'b0;
    logic [39:0]         acc_a = 40'h00_0000_0000;
    logic [39:0]         acc_b = 40'h00_0000_0000;
    bfs_pkg::bfs_instr_t instr;
    logic                sl_a;
    logic                sl_b;
    logic [2:0]          sa_a;
    logic [2:0]          sa_b;
    logic [7:0]          st_a;
    logic [7:0]          st_b;
    int                  miscompares = 0;
    int                  tests_run = 0;

    always #5 clock = ~clock;

    bfs_seq_model SEQ (.clock(clock), .instr(instr));

    bfs_ctrl DUT (
        .clock         (clock),
        .rst_b         (rst_b),
        .instr         (instr),
        .acc_a         (acc_a),
        .acc_b         (acc_b),
        .shift_left_a  (sl_a),
        .shift_amount_a(sa_a),
        .shift_left_b  (sl_b),
        .shift_amount_b(sa_b),
        .status_a      (st_a),
        .status_b      (st_b)
    );

    task automatic check(input logic [7:0] seen, input logic [7:0] expected);
        tests_run++;
        if (seen !== expected) begin
            miscompares++;
            $display("ERROR t=%0t seen=%h expected=%h", $time, seen, expected);
        end
    endtask

    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic send(input logic sel_b, input logic twos, input logic [39:0] value);
        if (sel_b) begin
            acc_b = value;
        end else begin
            acc_a = value;
        end
        SEQ.issue(bfs_pkg::BFS_OUTPUT, sel_b, twos, 8'h00);
    endtask

    initial begin
        repeat (20) @(posedge clock);
        #1 rst_b = 1'b1;
        check(st_a, 8'h80);
        check(st_b, 8'h80);
        check({4'h0, sl_a, sa_a}, 8'h00);
        $display("Test reset values done");
        SEQ.preload(1'b0, 4'h3);
        check({4'h0, sl_a, sa_a}, 8'h03);
        SEQ.start_pass();
        send(1'b0, 1'b0, 40'h00_8000_0000);
        check(st_a, 8'h03);
        send(1'b0, 1'b1, 40'h00_4000_0000);
        check(st_a, 8'h03);
        send(1'b0, 1'b0, 40'h01_0000_0000);
        check(st_a, 8'h13);
        send(1'b0, 1'b1, 40'h00_2000_0000);
        check(st_a, 8'h13);
        // Large value present but never output: must not be tracked
        acc_a = 40'h7F_0000_0000;
        repeat (3) @(posedge clock);
        #1 check(st_a, 8'h13);
        check(st_b, 8'h80);
        send(1'b1, 1'b1, 40'hFF_C000_0000);
        check(st_b, 8'hF0);
        $display("Test magnitude tracking done");
        SEQ.issue(bfs_pkg::BFS_UPDATE_SC, 1'b0, 1'b0, 8'h00);
        check(st_a, 8'h11);
        SEQ.issue(bfs_pkg::BFS_UPDATE_SC, 1'b0, 1'b0, 8'h00);
        check(st_a, 8'h13);
        SEQ.issue(bfs_pkg::BFS_WRITE_SC, 1'b1, 1'b0, 8'h08);
        check({4'h0, sl_b, sa_b}, 8'h0F);
        SEQ.issue(bfs_pkg::BFS_EQUALIZE, 1'b1, 1'b0, 8'h00);
        check(st_b, 8'hF3);
        $display("Test shift update done");
        send(1'b0, 1'b1, 40'h7F_0000_0000);
        check(st_a, 8'h73);
        SEQ.issue(bfs_pkg::BFS_WRITE_PM, 1'b0, 1'b0, 8'h05);
        check(st_a, 8'h53);
        SEQ.issue(bfs_pkg::BFS_WRITE_STATUS, 1'b1, 1'b0, 8'h27);
        check(st_b, 8'h27);
        SEQ.issue(bfs_pkg::BFS_UPDATE_SC, 1'b1, 1'b0, 8'h00);
        check(st_b, 8'h2B);
        check({4'h0, sl_b, sa_b}, 8'h0D);
        $display("Test writes and signed update done");
        // Normalization pass: last magnitude minus last shift, no growth
        SEQ.issue(bfs_pkg::BFS_WRITE_SC, 1'b0, 1'b0, 8'h05 - 8'h03);
        check(st_a, 8'h52);
        check({4'h0, sl_a, sa_a}, 8'h02);
        SEQ.issue(bfs_pkg::BFS_WRITE_SC, 1'b0, 1'b0, 8'h08);
        check({4'h0, sl_a, sa_a}, 8'h0F);
        SEQ.issue(bfs_pkg::BFS_EQUALIZE, 1'b0, 1'b0, 8'h00);
        check(st_a, 8'h5B);
        check({4'h0, sl_a, sa_a}, 8'h0D);
        $display("Test normalization pass and equalize done");
        // Mid-run reset returns both sets to their reset values
        rst_b = 1'b0;
        repeat (2) @(posedge clock);
        #1 rst_b = 1'b1;
        check(st_a, 8'h80);
        check(st_b, 8'h80);
        SEQ.issue(bfs_pkg::BFS_UPDATE_SC, 1'b0, 1'b0, 8'h00);
        check(st_a, 8'h88);
        check({4'h0, sl_a, sa_a}, 8'h0F);
        $display("Test mid-run reset done");
        report_and_stop();
    end

    // Whole sequence needs well under a thousand cycles
    initial begin
        #200000;
        miscompares++;
        report_and_stop();
    end
endmodule
